// *** pkg/lcd_cmd_pkg.sv ***
package lcd_cmd_pkg;

	// 7-bit slave address with the select bit at zero; the pin supplies bit 0
	localparam logic [6:0] SLAVE_ADDR_BASE = 7'h3C;

	// command field positions inside a command byte
	localparam int CONT_BIT = 7;
	localparam int XADDR_BIT = 6;
	localparam int MODE_TYPE_BIT = 4;

	// opcode patterns of the bits after the continuation flag
	localparam logic [1:0] OP_SET_MODE = 2'h2;
	localparam logic [4:0] OP_START_BANK = 5'h1F;
	localparam logic [2:0] OP_DEV_SELECT = 3'h6;
	localparam logic [2:0] OP_RAM_ACCESS = 3'h7;

	// access order encodings
	localparam logic [1:0] ORDER_CHAR = 2'h0;
	localparam logic [1:0] ORDER_HALF = 2'h1;
	localparam logic [1:0] ORDER_FULL = 2'h2;

	// address space limits
	localparam logic [5:0] COL_LAST = 6'h27;
	localparam logic [1:0] BANK_LAST = 2'h3;
	localparam logic [3:0] OWN_SUBADDR = 4'h0;

	// bit counts of one serial byte
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] RD_LAST_BIT = 4'h7;

	// power-on values
	localparam logic RST_MIXED = 1'b0;
	localparam logic [1:0] RST_DISP = 2'h0;
	localparam logic [1:0] RST_MUX = 2'h0;
	localparam logic [1:0] RST_TOP = 2'h0;
	localparam logic [3:0] RST_SUBADDR = 4'h0;
	localparam logic [1:0] RST_ORDER = 2'h0;
	localparam logic [1:0] RST_BANK = 2'h0;
	localparam logic [5:0] RST_COL = 6'h00;

	// synchroniser reset levels: idle bus lines are high, select pin low
	localparam logic [2:0] SYNC_RST = 3'h3;

	// serial slave states
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_CMD,
		ST_CMD_ACK,
		ST_DATA_WR,
		ST_DATA_ACK,
		ST_RD_LOAD,
		ST_RD_BYTE,
		ST_RD_ACK,
		ST_IGNORE
	} state_t;

endpackage

// *** rtl/lcd_serial_command_decoder.sv ***
`timescale 1ns/100ps
// Operation
// - answer one of two addresses differing in bit 0
// - address bit 0 follows the select pin
// - ack matching address, else ignore transfer
// - write transfers carry commands, always acked
// - command msb set means another command
// - ack data only when subaddress is ours
// - read goes straight to RAM data out
// - master nacks last byte; we release line
// - advance pointer per byte, subaddress on wrap
// - opcode 1,0 sets mode and system type
// - mux field selects scanned row count
// - status field selects blank/normal/on/inverse
// - opcode 1,1,1,1,1 loads start bank
// - opcode 1,1,0 loads subaddress counter
// - opcode 1,1,1 carries order and bank
// - order field: char, half, full graphic
// - bank field picks first data bank
// - opcode 0 loads six-bit column pointer
// - RAM traffic only at subaddress zero, mixed
// - RAM access only in mixed operation
// - subaddress counter wraps 15 to 0
module lcd_serial_command_decoder
	import lcd_cmd_pkg::*;
(
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oen_n_o,
	input wire logic addr_select_pin_i,
	input wire logic [7:0] ram_rdata_i,
	output logic ram_we_o,
	output logic ram_re_o,
	output logic [1:0] ram_bank_o,
	output logic [5:0] ram_col_o,
	output logic [7:0] ram_wdata_o,
	output logic mixed_mode_o,
	output logic [1:0] display_status_o,
	output logic [1:0] mux_rate_o,
	output logic [1:0] top_bank_o,
	output logic [3:0] subaddr_o,
	output logic [1:0] access_order_o
);

	// every flop of the block
	typedef struct packed {
		state_t st; // serial slave state
		logic [3:0] bitcnt; // bits seen or sent in this byte
		logic [7:0] shreg; // shift register, both directions
		logic rw; // read/write bit of the address
		logic cont; // continuation flag of last command
		logic mack; // master acked the byte just sent
		logic scl_prev; // filtered clock one cycle ago
		logic sda_prev; // filtered data one cycle ago
		logic sda_oen_n; // low while we pull the line down
		logic sda_lvl; // level driven when enabled
		logic mixed; // system type
		logic [1:0] disp; // display status
		logic [1:0] mux; // multiplex rate
		logic [1:0] top; // bank shown at top
		logic [3:0] subaddr; // subaddress counter
		logic [1:0] order; // auto-increment order
		logic [1:0] bank; // data pointer bank
		logic [5:0] col; // data pointer column
		logic we; // RAM write strobe
		logic re; // RAM read strobe
		logic [7:0] wdata; // RAM write data
	} ctl_t;

	ctl_t q;
	ctl_t d;
	logic [2:0] pins; // filtered scl, sda, select
	logic scl; // filtered clock line
	logic sda; // filtered data line
	logic sel; // filtered address select
	logic scl_rise; // clock went high
	logic scl_fall; // clock went low
	logic bus_start; // data fell with clock high
	logic bus_stop; // data rose with clock high
	logic ours; // data bytes belong to this device
	logic addr_hit; // received address matches
	logic [8:0] adv; // {subaddress step, bank, column}

	// bus lines and the strap come from outside the clock domain
	pin_sync u_sync (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.pins_i({addr_select_pin_i, sda_i, scl_i}),
		.pins_o(pins)
	);

	assign scl = pins[0];
	assign sda = pins[1];
	assign sel = pins[2];

	// line events seen at the system clock
	assign scl_rise = scl & ~q.scl_prev;
	assign scl_fall = ~scl & q.scl_prev;
	assign bus_start = scl & q.scl_prev & q.sda_prev & ~sda;
	assign bus_stop = scl & q.scl_prev & ~q.sda_prev & sda;

	// upper six bits fixed, lowest from the strap pin
	assign addr_hit = (q.shreg[7:2] == SLAVE_ADDR_BASE[6:1]) && (q.shreg[1] == sel);

	// the fixed subaddress only exists in mixed operation
	assign ours = q.mixed && (q.subaddr == OWN_SUBADDR);

	// next data pointer after one byte, in the selected order
	function automatic logic [8:0] next_ptr(
		input logic [1:0] order,
		input logic [1:0] bank,
		input logic [5:0] col
	);
		logic wrap;
		logic [1:0] b;
		logic [5:0] c;
		wrap = 1'b0;
		b = bank;
		c = col;
		case (order)
			ORDER_HALF:
			begin
				// pairs of banks share a column before it steps
				if (!bank[0])
				begin
					b[0] = 1'b1;
				end
				else if (col != COL_LAST)
				begin
					b[0] = 1'b0;
					c = col + 6'h01;
				end
				else
				begin
					b[0] = 1'b0;
					b[1] = ~bank[1];
					c = 6'h00;
					wrap = bank[1];
				end
			end
			ORDER_FULL:
			begin
				// all four banks of a column before the column steps
				if (bank != BANK_LAST)
				begin
					b = bank + 2'h1;
				end
				else if (col != COL_LAST)
				begin
					b = 2'h0;
					c = col + 6'h01;
				end
				else
				begin
					b = 2'h0;
					c = 6'h00;
					wrap = 1'b1;
				end
			end
			default:
			begin
				// character order: a whole bank row, then the next bank
				if (col != COL_LAST)
				begin
					c = col + 6'h01;
				end
				else
				begin
					c = 6'h00;
					b = bank + 2'h1;
					wrap = (bank == BANK_LAST);
				end
			end
		endcase
		return {wrap, b, c};
	endfunction

	assign adv = next_ptr(q.order, q.bank, q.col);

	// protocol engine and command decode
	always_comb
	begin
		d = q;
		d.we = 1'b0;
		d.re = 1'b0;
		d.scl_prev = scl;
		d.sda_prev = sda;
		if (bus_stop)
		begin
			// a stop always frees the line and ends the transfer
			d.st = ST_IDLE;
			d.sda_oen_n = 1'b1;
		end
		else if (bus_start)
		begin
			// start or repeated start: listen for an address
			d.st = ST_ADDR;
			d.bitcnt = 4'h0;
			d.sda_oen_n = 1'b1;
		end
		else
		begin
			case (q.st)
				ST_ADDR, ST_CMD, ST_DATA_WR:
				begin
					// receive: sample on the rising edge, act on the falling one
					if (scl_rise)
					begin
						d.shreg = {q.shreg[6:0], sda};
						d.bitcnt = q.bitcnt + 4'h1;
					end
					else if (scl_fall && q.bitcnt == BITS_PER_BYTE)
					begin
						d.bitcnt = 4'h0;
						if (q.st == ST_ADDR)
						begin
							if (addr_hit)
							begin
								d.rw = q.shreg[0];
								d.sda_oen_n = 1'b0;
								d.st = ST_ADDR_ACK;
							end
							else
							begin
								d.st = ST_IGNORE;
							end
						end
						else if (q.st == ST_CMD)
						begin
							// every command is acked by every addressed device
							d.sda_oen_n = 1'b0;
							d.cont = q.shreg[CONT_BIT];
							d.st = ST_CMD_ACK;
							if (!q.shreg[XADDR_BIT])
							begin
								// column values above the last one are stored as sent
								d.col = q.shreg[5:0];
							end
							else if (q.shreg[6:5] == OP_SET_MODE)
							begin
								d.mixed = q.shreg[MODE_TYPE_BIT];
								d.disp = q.shreg[3:2];
								d.mux = q.shreg[1:0];
							end
							else if (q.shreg[6:4] == OP_DEV_SELECT)
							begin
								d.subaddr = q.shreg[3:0];
							end
							else if (q.shreg[6:2] == OP_START_BANK)
							begin
								// checked first so low nibbles of 12 and up never reach ram access
								d.top = q.shreg[1:0];
							end
							else if (q.shreg[6:4] == OP_RAM_ACCESS)
							begin
								d.order = q.shreg[3:2];
								d.bank = q.shreg[1:0];
							end
						end
						else
						begin
							// data byte: only our subaddress stores and acks it
							if (ours)
							begin
								d.sda_oen_n = 1'b0;
								d.we = 1'b1;
								d.wdata = q.shreg;
							end
							d.st = ST_DATA_ACK;
						end
					end
				end
				ST_ADDR_ACK:
				begin
					// ack clock ends; choose write or read path
					if (scl_fall)
					begin
						d.sda_oen_n = 1'b1;
						if (!q.rw)
						begin
							d.st = ST_CMD;
						end
						else if (ours)
						begin
							d.re = 1'b1;
							d.st = ST_RD_LOAD;
						end
						else
						begin
							// row-only or foreign subaddress: receiving only
							d.st = ST_IGNORE;
						end
					end
				end
				ST_CMD_ACK:
				begin
					// the master must clear the flag before data follows
					if (scl_fall)
					begin
						d.sda_oen_n = 1'b1;
						d.st = q.cont ? ST_CMD : ST_DATA_WR;
					end
				end
				ST_DATA_ACK:
				begin
					// pointer steps for every data byte so cascaded parts keep count
					if (scl_fall)
					begin
						d.sda_oen_n = 1'b1;
						d.bank = adv[7:6];
						d.col = adv[5:0];
						d.subaddr = q.subaddr + {3'h0, adv[8]};
						d.st = ST_DATA_WR;
					end
				end
				ST_RD_LOAD:
				begin
					// read data must be valid by the clock edge that ends the strobe
					d.shreg = ram_rdata_i;
					d.sda_oen_n = ram_rdata_i[7];
					d.bitcnt = 4'h0;
					d.st = ST_RD_BYTE;
				end
				ST_RD_BYTE:
				begin
					// shift out msb first on each falling clock
					if (scl_fall)
					begin
						d.bitcnt = q.bitcnt + 4'h1;
						if (q.bitcnt == RD_LAST_BIT)
						begin
							d.sda_oen_n = 1'b1;
							d.st = ST_RD_ACK;
						end
						else
						begin
							d.shreg = {q.shreg[6:0], 1'b0};
							d.sda_oen_n = q.shreg[6];
						end
					end
				end
				ST_RD_ACK:
				begin
					// the master acks with a low level during the ninth clock
					if (scl_rise)
					begin
						d.mack = ~sda;
					end
					else if (scl_fall)
					begin
						d.bank = adv[7:6];
						d.col = adv[5:0];
						d.subaddr = q.subaddr + {3'h0, adv[8]};
						if (q.mack && adv[8] == 1'b0)
						begin
							d.re = 1'b1;
							d.st = ST_RD_LOAD;
						end
						else
						begin
							// no ack or our space ran out: leave the line high
							d.st = ST_IGNORE;
						end
					end
				end
				default:
				begin
					// idle or ignoring: hold the line released
					d.sda_oen_n = 1'b1;
				end
			endcase
		end
	end

	// registers
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			q.st <= ST_IDLE;
			q.bitcnt <= 4'h0;
			q.shreg <= 8'h00;
			q.rw <= 1'b0;
			q.cont <= 1'b0;
			q.mack <= 1'b0;
			q.scl_prev <= 1'b1;
			q.sda_prev <= 1'b1;
			q.sda_oen_n <= 1'b1;
			q.sda_lvl <= 1'b0;
			q.mixed <= RST_MIXED;
			q.disp <= RST_DISP;
			q.mux <= RST_MUX;
			q.top <= RST_TOP;
			q.subaddr <= RST_SUBADDR;
			q.order <= RST_ORDER;
			q.bank <= RST_BANK;
			q.col <= RST_COL;
			q.we <= 1'b0;
			q.re <= 1'b0;
			q.wdata <= 8'h00;
		end
		else
		begin
			q <= d;
		end
	end

	// outputs straight from flops
	assign sda_o = q.sda_lvl;
	assign sda_oen_n_o = q.sda_oen_n;
	assign ram_we_o = q.we;
	assign ram_re_o = q.re;
	assign ram_bank_o = q.bank;
	assign ram_col_o = q.col;
	assign ram_wdata_o = q.wdata;
	assign mixed_mode_o = q.mixed;
	assign display_status_o = q.disp;
	assign mux_rate_o = q.mux;
	assign top_bank_o = q.top;
	assign subaddr_o = q.subaddr;
	assign access_order_o = q.order;

endmodule

// *** rtl/pin_sync.sv ***
`timescale 1ns/100ps
// three-stage synchroniser with an agreement filter on the last two stages
module pin_sync
	import lcd_cmd_pkg::*;
(
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic [2:0] pins_i,
	output logic [2:0] pins_o
);

	// all flops of this module
	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] s3;
		logic [2:0] filt;
	} sync_t;

	sync_t q;
	sync_t d;
	logic [2:0] filt_next; // filtered value per line

	// a line only changes once stages two and three agree; stage one feeds stage two only
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_line
			assign filt_next[g] = (q.s2[g] == q.s3[g]) ? q.s3[g] : q.filt[g];
		end
	endgenerate

	// next state
	always_comb
	begin
		d = q;
		d.s1 = pins_i;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.filt = filt_next;
	end

	// registers
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			q <= {SYNC_RST, SYNC_RST, SYNC_RST, SYNC_RST};
		end
		else
		begin
			q <= d;
		end
	end

	assign pins_o = q.filt;

endmodule

// *** verification/bus_master_model.sv ***
`timescale 1ns/100ps
// bus master stand-in; the clock stays high between frames
module bus_master_model
(
	output logic scl_o,
	output logic sda_o,
	input wire logic sda_i
);
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// one 125 ns bit; data moves well after the fall to clear the filter
	task automatic bit_x(input logic b, output logic r);
		#16 sda_o = b;
		#15 scl_o = 1'b1;
		#31 r = sda_i;
		#31 scl_o = 1'b0;
		#32;
	endtask
	task automatic start();
		sda_o = 1'b1;
		#31 scl_o = 1'b1;
		#31 sda_o = 1'b0;
		#31 scl_o = 1'b0;
		#32;
	endtask
	// stop closes each transfer after its last byte, acknowledged or not
	task automatic stop();
		#16 sda_o = 1'b0;
		#15 scl_o = 1'b1;
		#31 sda_o = 1'b1;
		#63;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic nk);
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], nk);
		bit_x(1'b1, nk);
	endtask
	// the last read byte is left unacknowledged by the caller
	task automatic rbyte(input logic nk, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(1'b1, d[i]);
		bit_x(nk, r);
	endtask
endmodule

// *** verification/lcd_cmd_monitor.sv ***
`timescale 1ns/100ps
// port watcher of the decoder, one clock domain
module lcd_cmd_monitor
	import lcd_cmd_pkg::*;
(
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oen_n_o,
	input wire logic ram_we_o,
	input wire logic ram_re_o,
	input wire logic mixed_mode_o,
	input wire logic [3:0] subaddr_o,
	input wire logic [1:0] access_order_o
);
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rstn_i);
	// strobes last one cycle, so one byte never writes twice
	property p_we_pulse;
		ram_we_o |=> !ram_we_o;
	endproperty
	a_we_pulse: assert property (p_we_pulse) else $error("write strobe too long");
	property p_re_pulse;
		ram_re_o |=> !ram_re_o;
	endproperty
	a_re_pulse: assert property (p_re_pulse) else $error("read strobe too long");
	// ram traffic only for our own subaddress in mixed operation
	property p_we_own;
		ram_we_o |-> mixed_mode_o && subaddr_o == OWN_SUBADDR;
	endproperty
	a_we_own: assert property (p_we_own) else $error("write outside own space");
	property p_re_own;
		ram_re_o |-> mixed_mode_o && subaddr_o == OWN_SUBADDR;
	endproperty
	a_re_own: assert property (p_re_own) else $error("read outside own space");
	// open drain: the driven level is only ever low
	property p_sda_low;
		!sda_oen_n_o |-> sda_o == 1'b0;
	endproperty
	a_sda_low: assert property (p_sda_low) else $error("data pin driven high");
	property p_order_ok;
		access_order_o != 2'h3;
	endproperty
	a_order_ok: assert property (p_order_ok) else $error("illegal access order");
	// a pulled-low bit must stand well past the filter delay
	property p_ack_hold;
		$fell(sda_oen_n_o) |-> !sda_oen_n_o [*8];
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("pull-down too short");
	// changing the line while the clock is high would fake a start or stop
	property p_scl_low;
		$changed(sda_oen_n_o) |-> !scl_i;
	endproperty
	a_scl_low: assert property (p_scl_low) else $error("drive changed in clock high");
	c_we: cover property (ram_we_o);
	c_re: cover property (ram_re_o);
	c_ack: cover property ($fell(sda_oen_n_o));
endmodule
bind lcd_serial_command_decoder lcd_cmd_monitor u_mon (.clock_i(clock_i), .rstn_i(rstn_i),
	.scl_i(scl_i), .sda_o(sda_o), .sda_oen_n_o(sda_oen_n_o), .ram_we_o(ram_we_o),
	.ram_re_o(ram_re_o), .mixed_mode_o(mixed_mode_o), .subaddr_o(subaddr_o),
	.access_order_o(access_order_o));

// *** verification/lcd_serial_command_decoder_test.sv ***
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, a, b); end end
module lcd_serial_command_decoder_test
	import lcd_cmd_pkg::*;
;
	logic clock_i = 1'b0;
	logic rstn_i;
	logic scl, m_sda, sel, sda_o, oen_n, we, re, mixed;
	logic [7:0] rdata, wdata, d;
	logic [1:0] bank, disp, mux, top, order;
	logic [5:0] col;
	logic [3:0] sub;
	logic [31:0] rng = 32'h24;
	int fail_count = 0;
	int samples_checked = 0;
	logic [15:0] expq[$]; // {bank, column, data} of each expected write
	// pull-up wire: low whenever either party pulls
	wire sda_w = m_sda & (oen_n ? 1'b1 : sda_o);
	always #4 clock_i = ~clock_i;
	lcd_serial_command_decoder u_dut (.clock_i(clock_i), .rstn_i(rstn_i), .scl_i(scl),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oen_n_o(oen_n), .addr_select_pin_i(sel),
		.ram_rdata_i(rdata), .ram_we_o(we), .ram_re_o(re), .ram_bank_o(bank),
		.ram_col_o(col), .ram_wdata_o(wdata), .mixed_mode_o(mixed),
		.display_status_o(disp), .mux_rate_o(mux), .top_bank_o(top), .subaddr_o(sub),
		.access_order_o(order));
	bus_master_model u_m (.scl_o(scl), .sda_o(m_sda), .sda_i(sda_w));
	// ram stand-in returns {bank, column} so reads are self-describing
	always @(negedge clock_i)
		if (re === 1'b1)
			rdata <= {bank, col};
	// each write strobe consumes the oldest expectation
	always @(negedge clock_i)
		if (we === 1'b1)
		begin
			if (expq.size() == 0) `CHK(1'b1, 1'b0)
			else `CHK({bank, col, wdata}, expq.pop_front())
		end
	function automatic logic [7:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng[7:0];
	endfunction
	task automatic end_sim();
		if (fail_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// one written byte with its expected acknowledge level
	task automatic wr(input logic [7:0] v, input logic nk);
		logic r;
		u_m.wbyte(v, r);
		`CHK(r, nk)
	endtask
	// one data byte; acked ones are also expected in ram
	task automatic dat(input logic [1:0] b, input logic [5:0] c, input logic nk);
		logic [7:0] v;
		v = rnd();
		if (!nk)
			expq.push_back({b, c, v});
		wr(v, nk);
	endtask
	task automatic fr(input logic [7:0] a);
		u_m.start();
		wr(a, 1'b0);
	endtask
	// watchdog sized at several times the expected run
	initial
	begin
		#300000;
		fail_count++;
		end_sim();
	end
	initial
	begin
		rstn_i = 1'b0;
		sel = 1'b1;
		rdata = 8'h00;
		repeat (20) @(posedge clock_i);
		@(negedge clock_i) rstn_i = 1'b1;
		repeat (12) @(negedge clock_i);
		u_m.start();
		wr(8'h78, 1'b1);
		// a foreign address must leave the rest of the frame unheard
		wr(8'hEF, 1'b1);
		u_m.stop();
		`CHK(sub, 4'h0)
		fr(8'h7A);
		for (int i = 0; i < 4; i++)
		begin
			wr({4'hD, i[1:0], ~i[1:0]}, 1'b0);
			`CHK({mixed, disp, mux}, {1'b1, i[1:0], ~i[1:0]})
		end
		for (int i = 0; i < 3; i++)
		begin
			wr({4'hF, i[1:0], 2'h2}, 1'b0);
			`CHK({order, bank}, {i[1:0], 2'h2})
		end
		for (int i = 0; i < 4; i++)
		begin
			wr({6'h3F, i[1:0]}, 1'b0);
			`CHK({top, order, bank}, {i[1:0], 4'hA})
		end
		wr(8'hE0, 1'b0);
		wr(8'hF1, 1'b0);
		wr(8'h26, 1'b0);
		`CHK({sub, bank, col}, {4'h0, 2'h1, 6'h26})
		dat(2'h1, 6'h26, 1'b0);
		dat(2'h1, 6'h27, 1'b0);
		dat(2'h2, 6'h00, 1'b0);
		u_m.stop();
		fr(8'h7A);
		wr(8'hEF, 1'b0);
		wr(8'hF3, 1'b0);
		wr(8'h27, 1'b0);
		dat(2'h3, 6'h27, 1'b1);
		// the counter steps a few clocks after the ninth fall, behind the filter
		repeat (8) @(negedge clock_i);
		`CHK(sub, 4'h0)
		dat(2'h0, 6'h00, 1'b0);
		u_m.stop();
		// half-graphic order: bank pair alternates before the column steps
		fr(8'h7A);
		wr(8'hF4, 1'b0);
		wr(8'h10, 1'b0);
		dat(2'h0, 6'h10, 1'b0);
		dat(2'h1, 6'h10, 1'b0);
		dat(2'h0, 6'h11, 1'b0);
		u_m.stop();
		// full-graphic order: all banks of a column, then the next column
		fr(8'h7A);
		wr(8'hFA, 1'b0);
		wr(8'h20, 1'b0);
		dat(2'h2, 6'h20, 1'b0);
		dat(2'h3, 6'h20, 1'b0);
		dat(2'h0, 6'h21, 1'b0);
		u_m.stop();
		fr(8'h7A);
		wr(8'hF0, 1'b0);
		wr(8'h05, 1'b0);
		u_m.stop();
		fr(8'h7B);
		u_m.rbyte(1'b0, d);
		`CHK(d, 8'h05)
		u_m.rbyte(1'b1, d);
		`CHK(d, 8'h06)
		u_m.stop();
		fr(8'h7A);
		wr(8'hC1, 1'b0);
		`CHK(mixed, 1'b0)
		wr(8'h00, 1'b0);
		dat(2'h0, 6'h00, 1'b1);
		u_m.stop();
		fr(8'h7B);
		u_m.rbyte(1'b1, d);
		`CHK(d, 8'hFF)
		u_m.stop();
		repeat (20) @(negedge clock_i);
		`CHK(expq.size(), 0)
		end_sim();
	end
endmodule
